/* verilog/tbc_params.svh */
// Constants for the tape block check logic: offsets, fields, codes, timing.
`ifndef TBC_PARAMS_SVH
`define TBC_PARAMS_SVH

`define TBC_OFF_CTRL       8'h00
`define TBC_OFF_COUNT      8'h04
`define TBC_OFF_SENSE      8'h08
`define TBC_OFF_CHECK      8'h0c
`define TBC_OFF_IRQ_STAT   8'h10
`define TBC_OFF_IRQ_CLR    8'h14
`define TBC_OFF_IRQ_EN     8'h18

`define TBC_CTRL_DENS      8
`define TBC_CTRL_PANEL     9
`define TBC_CTRL_START     31

`define TBC_CMD_WRITE      8'h01
`define TBC_CMD_READ_BWD   8'h0c
`define TBC_CMD_READ_FWD   8'h02
`define TBC_CMD_BACKSPACE  8'h27
`define TBC_CMD_LOOP       8'h8b

`define TBC_POST_MIN       6'h06
`define TBC_POST_MAX       6'h32
`define TBC_POST_SAT       6'h3f
`define TBC_SYNC_EXTRA     13'h0002
`define TBC_PANEL_ZERO_LEN 12'h003
`define TBC_PANEL_FULL_LEN 12'h002
`define TBC_PANEL_ADD      12'h003
`define TBC_SHIFT_LOG2     3
`define TBC_SHIFT_EXTRA    10'h001

`define TBC_POLY_A         8'h1d
`define TBC_POLY_B         8'h07
`define TBC_CHECK_RESET    8'h00
`define TBC_IRQ_EN_RESET   3'h0

`define TBC_RESP_OKAY      2'h0
`define TBC_RESP_SLVERR    2'h2

`define TBC_CLK_PERIOD_NS  50
`define TBC_GAP_DELAY_NS   100

`endif

/* verilog/tbc_pkg.sv */
// Types and shared decode functions of the tape block check logic.
`include "tbc_params.svh"
package tbc_pkg;

  typedef enum logic [1:0]
  {
    TBC_IDLE   = 2'b00,
    TBC_RUN    = 2'b01,
    TBC_POST   = 2'b11,
    TBC_FINISH = 2'b10
  } tbc_state_type;

  typedef struct packed
  {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
  } tbc_gen_state_type;

  typedef struct packed
  {
    logic          awHeld;
    logic [7:0]    awAddr;
    logic          awReady;
    logic          wHeld;
    logic [31:0]   wData;
    logic [3:0]    wStrb;
    logic          wReady;
    logic          bValid;
    logic [1:0]    bResp;
    logic          arReady;
    logic          rValid;
    logic [31:0]   rData;
    logic [1:0]    rResp;
    logic [7:0]    cmd;
    logic          dens;
    logic          panel;
    logic [11:0]   count;
    tbc_state_type state;
    logic [7:0]    cmdQ;
    logic          pe;
    logic [11:0]   blockLen;
    logic [12:0]   syncCnt;
    logic [12:0]   target;
    logic [5:0]    postCnt;
    logic          allOnes;
    logic          postSeen;
    logic [9:0]    shiftRem;
    logic          shiftPulse;
    logic          eodPulse;
    logic          gapOn;
    logic          gapGoal;
    logic [1:0]    gapCnt;
    logic          s3b3;
    logic          s5b5;
    logic          s5b6;
    logic          s9b3;
    logic          goodOut;
    logic [2:0]    irqStat;
    logic [2:0]    irqEn;
    logic          irq;
    logic          genClear;
    logic          genShift;
    logic [7:0]    genData;
    logic [7:0]    dReg;
    logic [7:0]    checkOut;
    logic          checkValid;
  } tbc_top_state_type;

  function automatic logic tbc_is_read(input logic [7:0] cmd);
    return (cmd == `TBC_CMD_READ_FWD) || (cmd == `TBC_CMD_READ_BWD);
  endfunction

  function automatic logic tbc_is_write(input logic [7:0] cmd);
    return (cmd == `TBC_CMD_WRITE) || (cmd == `TBC_CMD_LOOP);
  endfunction

  function automatic logic [11:0] tbc_panel_len(input logic [7:0] cnt);
    if (cnt == 8'h00)
      return `TBC_PANEL_ZERO_LEN;
    else if (cnt == 8'hff)
      return `TBC_PANEL_FULL_LEN;
    else
      return {4'h0, cnt} + `TBC_PANEL_ADD;
  endfunction

  function automatic logic [7:0] tbc_crc_step(input logic [7:0] crc,
                                               input logic [7:0] data,
                                               input logic [7:0] poly);
    logic [7:0] x;
    x = crc ^ data;
    for (int i = 0; i < 8; i++)
      x = x[7] ? ((x << 1) ^ poly) : (x << 1);
    return x;
  endfunction

endpackage

/* verilog/tbc_gen_if.sv */
// Carrier between the sequencer and the check byte generators.
`timescale 1ns/100ps
interface tbc_gen_if;
  logic       clear;
  logic       shift;
  logic [7:0] data;
  logic [7:0] regA;
  logic [7:0] regB;
  logic [7:0] regC;

  modport ctl (output clear, output shift, output data,
               input regA, input regB, input regC);
  modport gen (input clear, input shift, input data,
               output regA, output regB, output regC);
endinterface

/* verilog/tbc_check_gen.sv */
// Check byte generators A, B and C fed one data byte per shift.
`timescale 1ns/100ps
`include "tbc_params.svh"
module tbc_check_gen
(
  input wire logic clk,
  input wire logic rst_b,
  tbc_gen_if.gen   genIf
);

  tbc_pkg::tbc_gen_state_type q;
  tbc_pkg::tbc_gen_state_type d;

  // C runs the same step as B on its own flops so the two can be compared.
  always_comb
  begin
    d = q;
    if (genIf.clear)
      d = '0;
    else if (genIf.shift)
    begin
      d.a = tbc_pkg::tbc_crc_step(q.a, genIf.data, `TBC_POLY_A);
      d.b = tbc_pkg::tbc_crc_step(q.b, genIf.data, `TBC_POLY_B);
      d.c = tbc_pkg::tbc_crc_step(q.c, genIf.data, `TBC_POLY_B);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '{`TBC_CHECK_RESET, `TBC_CHECK_RESET, `TBC_CHECK_RESET};
    else
      q <= d;
  end

  assign genIf.regA = q.a;
  assign genIf.regB = q.b;
  assign genIf.regC = q.c;

endmodule // tbc_check_gen

/* verilog/tbc_top.sv */
// Block check, end-of-data and gap window logic with an AXI4-Lite slave.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "tbc_params.svh"
module tbc_top
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        atLoadPoint,
  input  wire logic        byteSync,
  input  wire logic        tapeByteValid,
  input  wire logic [7:0]  tapeByte,
  input  wire logic        allOnesMarker,
  input  wire logic        preambleStart,
  input  wire logic        postambleByte,
  input  wire logic        postambleEnd,
  input  wire logic        recordedCheckValid,
  input  wire logic [7:0]  recordedCheck,
  output logic             gapWindowBranch,
  output logic             endOfData,
  output logic             checkShift,
  output logic [7:0]       checkByteOut,
  output logic             checkByteValid,
  output logic             endOrCheckGood,
  output logic             thirdCheckError,
  output logic             irq
);

  localparam int GapCyc =
    (`TBC_GAP_DELAY_NS + `TBC_CLK_PERIOD_NS - 1) / `TBC_CLK_PERIOD_NS;

  tbc_pkg::tbc_top_state_type q;
  tbc_pkg::tbc_top_state_type d;
  tbc_gen_if genIf ();

  logic        startCmd;
  logic        peRead;
  logic        endErr;
  logic        chkErr;
  logic [2:0]  clrMask;
  logic [2:0]  evtSet;
  logic [11:0] lenSel;
  logic [31:0] wr;

  function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  tbc_check_gen u_gen
  (
    .clk   (clk),
    .rst_b (rst_b),
    .genIf (genIf)
  );

  assign genIf.clear = q.genClear;
  assign genIf.shift = q.genShift;
  assign genIf.data  = q.genData;

  always_comb
  begin
    d          = q;
    startCmd   = 1'b0;
    clrMask    = 3'h0;
    evtSet     = 3'h0;
    lenSel     = 12'h000;
    wr         = 32'h0000_0000;
    peRead     = q.pe && tbc_pkg::tbc_is_read(q.cmdQ);
    endErr     = !q.allOnes || (q.postCnt < `TBC_POST_MIN) ||
                 (q.postCnt > `TBC_POST_MAX);
    chkErr     = 1'b0;
    if (q.pe)
      chkErr = tbc_pkg::tbc_is_write(q.cmdQ) &&
               (genIf.regC != genIf.regB);
    else if (tbc_pkg::tbc_is_write(q.cmdQ) ||
             q.cmdQ == `TBC_CMD_READ_FWD)
      chkErr = genIf.regB != q.dReg;
    else if (q.cmdQ == `TBC_CMD_READ_BWD)
      chkErr = (genIf.regA ^ genIf.regC) != q.dReg;
    d.eodPulse   = 1'b0;
    d.shiftPulse = 1'b0;
    d.genShift   = 1'b0;
    d.genClear   = 1'b0;
    d.checkValid = 1'b0;

    if (awvalid && q.awReady)
    begin
      d.awHeld = 1'b1;
      d.awAddr = awaddr;
    end
    if (wvalid && q.wReady)
    begin
      d.wHeld = 1'b1;
      d.wData = wdata;
      d.wStrb = wstrb;
    end
    if (q.bValid && bready)
      d.bValid = 1'b0;
    if (d.awHeld && d.wHeld && !q.bValid)
    begin
      d.awHeld = 1'b0;
      d.wHeld  = 1'b0;
      d.bValid = 1'b1;
      d.bResp  = `TBC_RESP_OKAY;
      case (d.awAddr)
        `TBC_OFF_CTRL:
        begin
          wr = merge_strb({22'h0, q.panel, q.dens, q.cmd}, d.wData, d.wStrb);
          d.cmd   = wr[7:0];
          d.dens  = wr[`TBC_CTRL_DENS];
          d.panel = wr[`TBC_CTRL_PANEL];
          startCmd = d.wStrb[3] && d.wData[`TBC_CTRL_START] &&
                     (q.state == tbc_pkg::TBC_IDLE);
        end
        `TBC_OFF_COUNT:
        begin
          wr = merge_strb({20'h0, q.count}, d.wData, d.wStrb);
          d.count = wr[11:0];
        end
        `TBC_OFF_IRQ_CLR:
          clrMask = d.wData[2:0] & {3{d.wStrb[0]}};
        `TBC_OFF_IRQ_EN:
          if (d.wStrb[0])
            d.irqEn = d.wData[2:0];
        `TBC_OFF_SENSE, `TBC_OFF_CHECK, `TBC_OFF_IRQ_STAT:
          d.bResp = `TBC_RESP_OKAY;
        default:
          d.bResp = `TBC_RESP_SLVERR;
      endcase
    end
    d.awReady = !d.awHeld && !d.bValid;
    d.wReady  = !d.wHeld && !d.bValid;

    if (q.rValid && rready)
      d.rValid = 1'b0;
    if (arvalid && q.arReady)
    begin
      d.rValid = 1'b1;
      d.rResp  = `TBC_RESP_OKAY;
      case (araddr)
        `TBC_OFF_CTRL:     d.rData = {22'h0, q.panel, q.dens, q.cmd};
        `TBC_OFF_COUNT:    d.rData = {20'h0, q.count};
        `TBC_OFF_SENSE:
          d.rData = {26'h0, q.pe, q.state != tbc_pkg::TBC_IDLE,
                     q.s9b3, q.s5b6, q.s5b5, q.s3b3};
        `TBC_OFF_CHECK:
          d.rData = {q.dReg, genIf.regC, genIf.regB, genIf.regA};
        `TBC_OFF_IRQ_STAT: d.rData = {29'h0, q.irqStat};
        `TBC_OFF_IRQ_CLR:  d.rData = 32'h0000_0000;
        `TBC_OFF_IRQ_EN:   d.rData = {29'h0, q.irqEn};
        default:
        begin
          d.rData = 32'h0000_0000;
          d.rResp = `TBC_RESP_SLVERR;
        end
      endcase
    end
    d.arReady = !d.rValid;

    // Kept alive past the end of a command, the postamble may close late.
    if (tbc_pkg::tbc_is_read(q.cmdQ))
    begin
      if (preambleStart)
      begin
        d.gapGoal = 1'b1;
        d.gapCnt  = 2'(GapCyc - 1);
      end
      else if (postambleEnd)
      begin
        d.gapGoal = 1'b0;
        d.gapCnt  = 2'(GapCyc - 1);
      end
      else if (q.gapCnt != 2'h0)
        d.gapCnt = q.gapCnt - 2'h1;
      else
        d.gapOn = q.gapGoal;
    end

    if (q.state != tbc_pkg::TBC_IDLE)
    begin
      if (recordedCheckValid)
        d.dReg = recordedCheck;
      if (allOnesMarker)
        d.allOnes = 1'b1;
      if (postambleEnd)
        d.postSeen = 1'b1;
    end

    case (q.state)
      tbc_pkg::TBC_IDLE:
        if (startCmd)
        begin
          d.state  = tbc_pkg::TBC_RUN;
          d.cmdQ   = d.cmd;
          d.pe     = (d.cmd == `TBC_CMD_LOOP && atLoadPoint) || !d.dens;
          lenSel   = (d.panel && tbc_pkg::tbc_is_write(d.cmd)) ?
                     tbc_pkg::tbc_panel_len(d.count[7:0]) : d.count;
          d.blockLen = lenSel;
          d.target   = {1'b0, lenSel} + `TBC_SYNC_EXTRA;
          d.syncCnt  = 13'h0000;
          d.postCnt  = 6'h00;
          d.allOnes  = 1'b0;
          d.postSeen = 1'b0;
          d.s3b3     = 1'b0;
          d.s5b5     = 1'b0;
          d.s5b6     = 1'b0;
          d.s9b3     = 1'b0;
          d.goodOut  = 1'b0;
          d.gapOn    = 1'b0;
          d.gapGoal  = 1'b0;
          d.gapCnt   = 2'h0;
          d.genClear = 1'b1;
        end
      tbc_pkg::TBC_RUN:
      begin
        if (tapeByteValid)
        begin
          d.genShift = 1'b1;
          d.genData  = tapeByte;
        end
        if (byteSync)
        begin
          d.syncCnt = q.syncCnt + 13'h0001;
          if (d.syncCnt == q.target)
          begin
            d.eodPulse = 1'b1;
            d.state    = tbc_pkg::TBC_POST;
            d.shiftRem = q.pe ? 10'h000 :
                         10'(q.blockLen >> `TBC_SHIFT_LOG2) +
                         `TBC_SHIFT_EXTRA;
          end
        end
      end
      tbc_pkg::TBC_POST:
      begin
        if (postambleByte && q.postCnt != `TBC_POST_SAT)
          d.postCnt = q.postCnt + 6'h01;
        if (q.shiftRem != 10'h000)
        begin
          d.shiftPulse = 1'b1;
          d.shiftRem   = q.shiftRem - 10'h001;
        end
        else if (!peRead || q.postSeen)
          d.state = tbc_pkg::TBC_FINISH;
      end
      tbc_pkg::TBC_FINISH:
      begin
        d.s3b3    = peRead ? endErr : chkErr;
        d.s5b5    = peRead && !q.allOnes;
        d.s5b6    = peRead && q.allOnes &&
                    (q.postCnt > `TBC_POST_MAX);
        d.s9b3    = chkErr;
        d.goodOut = !d.s3b3;
        evtSet    = {chkErr, peRead && endErr, 1'b1};
        if (!q.pe && tbc_pkg::tbc_is_write(q.cmdQ))
        begin
          d.checkOut   = genIf.regA;
          d.checkValid = 1'b1;
        end
        d.state = tbc_pkg::TBC_IDLE;
      end
      default:
        d.state = tbc_pkg::TBC_IDLE;
    endcase

    // A new event beats a clear written in the same cycle.
    d.irqStat = (q.irqStat & ~clrMask) | evtSet;
    d.irq     = |(d.irqStat & d.irqEn);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q          <= '0;
      q.state    <= tbc_pkg::TBC_IDLE;
      q.irqEn    <= `TBC_IRQ_EN_RESET;
      q.dReg     <= `TBC_CHECK_RESET;
      q.checkOut <= `TBC_CHECK_RESET;
    end
    else
      q <= d;
  end

  assign awready         = q.awReady;
  assign wready          = q.wReady;
  assign bvalid          = q.bValid;
  assign bresp           = q.bResp;
  assign arready         = q.arReady;
  assign rvalid          = q.rValid;
  assign rdata           = q.rData;
  assign rresp           = q.rResp;
  assign gapWindowBranch = q.gapOn;
  assign endOfData       = q.eodPulse;
  assign checkShift      = q.shiftPulse;
  assign checkByteOut    = q.checkOut;
  assign checkByteValid  = q.checkValid;
  assign endOrCheckGood  = q.goodOut;
  assign thirdCheckError = q.s9b3;
  assign irq             = q.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic inFinish;
  assign inFinish = q.state == tbc_pkg::TBC_FINISH;

  sequence gap_open_s;
    tbc_pkg::tbc_is_read(q.cmdQ) && preambleStart
      ##1 (!preambleStart && !postambleEnd)[*2];
  endsequence

  sequence last_sync_s;
    q.state == tbc_pkg::TBC_RUN && byteSync &&
      (q.syncCnt + 13'h0001 == q.target);
  endsequence

  short_post_a: assert property (inFinish && peRead && q.allOnes &&
      q.postCnt < `TBC_POST_MIN |=> q.s3b3 && !q.s5b6 && !q.s5b5)
    else $error("short postamble not reported");

  partial_rec_a: assert property (inFinish && peRead &&
      !q.allOnes |=> q.s5b5 && !q.s5b6 && q.s3b3)
    else $error("missing marker not reported as partial record");

  check_report_a: assert property (inFinish && !peRead |=>
      q.s3b3 == $past(chkErr) && !q.s5b5 && !q.s5b6)
    else $error("end-data bit does not carry the check result");

  sense_pair_a: assert property ($rose(q.s9b3) |-> q.s3b3)
    else $error("third check error without end-data sense");

  eod_count_a: assert property (last_sync_s |=> endOfData ##1
      !endOfData)
    else $error("end of data not signalled after count plus two");

  shift_count_a: assert property (q.state == tbc_pkg::TBC_POST &&
      q.shiftRem != 10'h000 |=> checkShift &&
      q.shiftRem == $past(q.shiftRem) - 10'h001)
    else $error("check shift pulse missing");

  gap_rise_a: assert property (gap_open_s |=> gapWindowBranch)
    else $error("gap branch did not rise after preamble");

  sense_clear_a: assert property (startCmd |=> !q.s3b3 &&
      !q.s5b5 && !q.s5b6 && !q.s9b3 && q.state == tbc_pkg::TBC_RUN)
    else $error("sense bits not cleared at command start");

  loop_pe_a: assert property (startCmd &&
      d.cmd == `TBC_CMD_LOOP && atLoadPoint |=> q.pe)
    else $error("loop at load point not in PE mode");

  dreg_load_a: assert property (q.state != tbc_pkg::TBC_IDLE &&
      recordedCheckValid |=> q.dReg == $past(recordedCheck))
    else $error("recorded check byte not held");

endmodule // tbc_top

/* sim/tbc_tape_model.sv */
// Tape data path model that plays one block of syncs, bytes and postamble.
`timescale 1ns/100ps
module tbc_tape_model
(
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [11:0] nData,
  input  wire logic [5:0]  nPost,
  input  wire logic        mark,
  input  wire logic [7:0]  dByte,
  input  wire logic        endOfData,
  output logic             byteSync,
  output logic             tapeByteValid,
  output logic [7:0]       tapeByte,
  output logic             allOnesMarker,
  output logic             preambleStart,
  output logic             postambleByte,
  output logic             postambleEnd,
  output logic             recordedCheckValid,
  output logic [7:0]       recordedCheck,
  output logic [12:0]      syncsAtEod,
  output logic             busy
);
  logic [12:0] syncs;

  // One step drives all five tape strobes and the byte valid, so none is ever left high by mistake.
  task automatic step(input logic [4:0] s, input logic v,
                      input logic [7:0] b);
    {preambleStart, byteSync, allOnesMarker, postambleByte,
     postambleEnd} <= s;
    tapeByteValid <= v;
    // An idle data line toggles so a stale byte never looks valid.
    tapeByte <= v ? b : ~tapeByte;
    if (s[3]) syncs <= syncs + 13'h0001;
    @(posedge clk);
  endtask

  initial
  begin
    {busy, syncs, syncsAtEod} = 27'h0;
    {recordedCheckValid, recordedCheck} = 9'h0;
    {preambleStart, byteSync, allOnesMarker, postambleByte} = 4'h0;
    {postambleEnd, tapeByteValid, tapeByte} = 10'h0;
  end

  always @(posedge clk)
    if (endOfData) syncsAtEod <= syncs;

  // Extra syncs after the data let the block run past its end of data.
  always @(posedge clk)
    if (go)
    begin
      busy <= 1'b1;
      syncs <= 13'h0000;
      recordedCheckValid <= 1'b1;
      recordedCheck <= dByte;
      step(5'h10, 1'b0, 8'h00);
      recordedCheckValid <= 1'b0;
      recordedCheck <= ~dByte;
      repeat (4) step(5'h00, 1'b0, 8'h00);
      for (int i = 0; i < nData + 4; i++)
      begin
        step(5'h08, i < nData, 8'h5a ^ i[7:0]);
        step(5'h00, 1'b0, 8'h00);
      end
      if (mark) step(5'h04, 1'b0, 8'h00);
      repeat (nPost)
      begin
        step(5'h02, 1'b0, 8'h00);
        step(5'h00, 1'b0, 8'h00);
      end
      step(5'h01, 1'b0, 8'h00);
      repeat (4) step(5'h00, 1'b0, 8'h00);
      busy <= 1'b0;
    end
endmodule // tbc_tape_model

/* sim/testbench.sv */
// Self-checking bench of the tape block check logic.
`timescale 1ns/100ps
`include "tbc_params.svh"
module testbench;
  logic        clk, rst_b, atLoadPoint;
  logic [7:0]  awaddr, araddr, tapeByte, recordedCheck, checkByteOut;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic        byteSync, tapeByteValid, allOnesMarker, preambleStart;
  logic        postambleByte, postambleEnd, recordedCheckValid;
  logic        gapWindowBranch, endOfData, checkShift, checkByteValid;
  logic        endOrCheckGood, thirdCheckError, irq;
  logic        go, mark, isRead, mBusy;
  logic [11:0] nData;
  logic [5:0]  nPost;
  logic [7:0]  dByte, aByte;
  logic [12:0] syncsAtEod;
  int          shiftCnt, miscompares = 0, totalChecks = 0;

  tbc_top u_dut (.clk, .rst_b, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .atLoadPoint,
    .byteSync, .tapeByteValid, .tapeByte, .allOnesMarker, .preambleStart,
    .postambleByte, .postambleEnd, .recordedCheckValid, .recordedCheck,
    .gapWindowBranch, .endOfData, .checkShift, .checkByteOut,
    .checkByteValid, .endOrCheckGood, .thirdCheckError, .irq);
  tbc_tape_model u_tape (.clk, .go, .nData, .nPost, .mark, .dByte,
    .endOfData, .byteSync, .tapeByteValid, .tapeByte, .allOnesMarker,
    .preambleStart, .postambleByte, .postambleEnd, .recordedCheckValid,
    .recordedCheck, .syncsAtEod, .busy(mBusy));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (checkShift) shiftCnt <= shiftCnt + 1;
    if (checkByteValid) aByte <= checkByteOut;
  end

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    totalChecks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask

  // Ready stays low while bvalid is high, so back-to-back calls never
  // assign it twice in one time step.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    rsp = bresp;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    rsp = rresp;
  endtask

  function automatic logic [7:0] gen(input int n, input logic [7:0] p);
    logic [7:0] x;
    x = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      x = x ^ 8'h5a ^ i[7:0];
      for (int k = 0; k < 8; k++)
        x = x[7] ? ((x << 1) ^ p) : (x << 1);
    end
    return x;
  endfunction

  // Runs one command; m holds panel, density and command code.
  task automatic blk(input logic [11:0] c, input logic [9:0] m,
    input logic [11:0] nd, input logic [5:0] np, input logic mk,
    input logic [7:0] d);
    axw(8'h04, {20'h0, c});
    {nData, nPost, mark, dByte} <= {nd, np, mk, d};
    isRead <= m[7:0] == 8'h02 || m[7:0] == 8'h0c;
    shiftCnt <= 0;
    axw(8'h00, {1'b1, 21'h0, m});
    axr(8'h08, v);
    chk("sense at start", 32'h0, {28'h0, v[3:0]});
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (mBusy) @(posedge clk);
    do axr(8'h08, v); while (v[4]);
  endtask

  initial
  forever
  begin
    @(posedge clk iff preambleStart);
    repeat (3) @(posedge clk);
    chk("gap up", {31'h0, isRead}, {31'h0, gapWindowBranch});
    @(posedge clk iff postambleEnd);
    repeat (3) @(posedge clk);
    chk("gap down", 32'h0, {31'h0, gapWindowBranch});
  end

  task automatic t_pe;
    logic [9:0] tb [6] = '{10'h0a8, 10'h059, 10'h068, 10'h328,
                           10'h33d, 10'h143};
    foreach (tb[i])
    begin
      blk(12'h004, 10'h002, 12'h004, tb[i][9:4], tb[i][3], 8'h00);
      chk("end data", {29'h0, tb[i][2:0]}, {29'h0, v[2:0]});
      chk("good", {31'h0, !tb[i][0]}, {31'h0, endOrCheckGood});
      chk("eod syncs", 32'h6, {19'h0, syncsAtEod});
    end
    blk(12'h004, 10'h001, 12'h004, 6'h0a, 1'b1, 8'h00);
    chk("pe write", 32'h0, {28'h0, v[3:0]});
    $display("pe tests done");
  endtask

  task automatic t_dense;
    logic [7:0] cm [3] = '{8'h01, 8'h02, 8'h0c};
    logic [7:0] a, b, d;
    a = gen(176, `TBC_POLY_A);
    b = gen(176, `TBC_POLY_B);
    foreach (cm[i])
      for (int bad = 0; bad < 2; bad++)
      begin
        d = (cm[i] == 8'h0c) ? (a ^ b) : b;
        blk(12'h0b0, {2'b01, cm[i]}, 12'h0b0, 6'h0a, 1'b1, d ^ bad[7:0]);
        chk("check err", {30'h0, bad[0], bad[0]}, {30'h0, v[3], v[0]});
        chk("third", {31'h0, bad[0]}, {31'h0, thirdCheckError});
        chk("shifts", 32'h17, shiftCnt);
        chk("eod syncs", 32'hb2, {19'h0, syncsAtEod});
        if (i == 0 && bad == 0)
        begin
          chk("a out", {24'h0, a}, {24'h0, aByte});
          axr(8'h0c, v);
          chk("check reg", {d, b, b, a}, v);
        end
      end
    $display("6250 tests done");
  endtask

  task automatic t_panel;
    logic [19:0] tb [4] = '{20'h00003, 20'h01004, 20'hfe101, 20'hff002};
    foreach (tb[i])
    begin
      blk({4'h0, tb[i][19:12]}, 10'h201, tb[i][11:0], 6'h0a, 1'b1, 8'h00);
      chk("panel", {19'h0, tb[i][11:0] + 13'h2}, {19'h0, syncsAtEod});
    end
    for (int lp = 0; lp < 2; lp++)
    begin
      atLoadPoint <= lp[0];
      blk(12'h004, 10'h18b, 12'h004, 6'h0a, 1'b1, 8'h00);
      chk("loop pe", {31'h0, lp[0]}, {31'h0, v[5]});
    end
    $display("panel and loop tests done");
  endtask

  task automatic t_irq;
    axr(8'h18, v);
    chk("irq en reset", 32'h0, v);
    axr(8'h40, v);
    chk("unmapped", 32'h2, {30'h0, rsp});
    axw(8'h14, 32'h7);
    blk(12'h004, 10'h027, 12'h004, 6'h0a, 1'b1, 8'h00);
    axr(8'h10, v);
    chk("irq stat", 32'h1, v);
    chk("irq masked", 32'h0, {31'h0, irq});
    axw(8'h18, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq on", 32'h1, {31'h0, irq});
    axw(8'h14, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("irq tests done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {go, mark, isRead, atLoadPoint, awaddr, araddr} = 20'h0;
    {wdata, nData, nPost, dByte, shiftCnt} = 90'h0;
    wstrb = 4'hf;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    t_irq;
    t_pe;
    t_dense;
    t_panel;
    print_verdict;
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
endmodule // testbench
